// ---- dv/test_udp_mac_packet_adapter.sv ----
`timescale 1ns/1ps
// ***
// Testbench
// ***
module test_udp_mac_packet_adapter
	import umpa_pkg::*;
;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic mac_transmit_clock = 1'h0;
	logic mac_receive_clock = 1'h0;
	logic engine_tx_push = 1'h0;
	logic engine_tx_end = 1'h0;
	logic engine_rx_pop = 1'h0;
	logic [DATA_W-1:0] engine_tx_word = '0;
	logic [4:0] final_beat_empty_bytes = 5'h04;
	logic [1:0] stall_mode = 2'h0;
	logic [DATA_W-1:0] engine_rx_word, mac_tx_word, mac_rx_word;
	logic [4:0] engine_rx_empty_bytes, mac_tx_empty, mac_rx_empty;
	logic outbound_queue_full, engine_rx_end, inbound_queue_empty, mac_tx_accept;
	logic mac_tx_word_valid, mac_tx_packet_start, mac_tx_packet_end;
	logic mac_rx_word_valid, mac_rx_packet_end;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;

	always #10 clk = ~clk;
	always #15 mac_transmit_clock = ~mac_transmit_clock;
	initial #4 forever #15 mac_receive_clock = ~mac_receive_clock;

	umpa_adapter i_umpa_adapter (.clk, .rst_b, .mac_transmit_clock, .mac_receive_clock,
		.engine_tx_push, .engine_tx_word, .engine_tx_end, .final_beat_empty_bytes,
		.outbound_queue_full, .engine_rx_pop, .engine_rx_word, .engine_rx_end,
		.engine_rx_empty_bytes, .inbound_queue_empty, .mac_tx_accept, .mac_tx_word,
		.mac_tx_word_valid, .mac_tx_packet_start, .mac_tx_packet_end, .mac_tx_empty,
		.mac_rx_word, .mac_rx_word_valid, .mac_rx_packet_end, .mac_rx_empty);
	umpa_mac_model i_umpa_mac_model (.mac_transmit_clock, .mac_receive_clock, .stall_mode,
		.mac_tx_accept, .mac_tx_word, .mac_tx_word_valid, .mac_tx_packet_end, .mac_tx_empty,
		.mac_rx_word, .mac_rx_word_valid, .mac_rx_packet_end, .mac_rx_empty);

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out;
		$display("checks=%0d mismatches=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	task automatic push_pkt(input int n, input logic [31:0] base, input logic [4:0] emp);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			engine_tx_push <= 1'h1;
			engine_tx_word <= {8{base + 32'(i)}};
			engine_tx_end <= (i == n - 1);
			final_beat_empty_bytes <= emp;
		end
		@(posedge clk);
		engine_tx_push <= 1'h0;
		engine_tx_end <= 1'h0;
	endtask : push_pkt

	task automatic expect_tx(input int n, input logic [31:0] base, input logic [4:0] emp);
		logic [DATA_W+5:0] b;
		for (int i = 0; i < n; i++)
		begin
			for (int k = 0; k < 400 && i_umpa_mac_model.got.size() == 0; k++)
				@(posedge clk);
			b = i_umpa_mac_model.got.pop_front();
			check(b[DATA_W+5:6], {8{base + 32'(i)}});
			check(b[5], (i == n - 1));
			check(b[4:0], (i == n - 1) ? emp : 5'h00);
		end
	endtask : expect_tx

	task automatic pop_expect(input int n, input logic [31:0] base, input logic [4:0] emp);
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk);
			for (int k = 0; k < 400 && inbound_queue_empty !== 1'h0; k++)
				@(negedge clk);
			check(engine_rx_word, {8{base + 32'(i)}});
			check(engine_rx_end, (i == n - 1));
			check(engine_rx_empty_bytes, emp);
			@(posedge clk);
			engine_rx_pop <= 1'h1;
			@(posedge clk);
			engine_rx_pop <= 1'h0;
		end
	endtask : pop_expect

	task automatic t_tx_back;
		push_pkt(3, 32'h100, 5'h16);
		push_pkt(1, 32'h200, 5'h04);
		expect_tx(3, 32'h100, 5'h16);
		expect_tx(1, 32'h200, 5'h04);
		$display("t_tx_back done");
	endtask : t_tx_back

	task automatic t_tx_stall;
		stall_mode <= 2'h3;
		push_pkt(6, 32'h300, 5'h16);
		expect_tx(6, 32'h300, 5'h16);
		stall_mode <= 2'h1;
		push_pkt(2, 32'h400, 5'h04);
		expect_tx(2, 32'h400, 5'h04);
		$display("t_tx_stall done");
	endtask : t_tx_stall

	task automatic t_duplex;
		fork
			push_pkt(2, 32'h500, 5'h16);
			i_umpa_mac_model.send_rx(4, 32'h600, 5'h16, 1'h1);
		join
		expect_tx(2, 32'h500, 5'h16);
		pop_expect(4, 32'h600, 5'h16);
		$display("t_duplex done");
	endtask : t_duplex

	// Nothing leaves before the end beat lands, so a packet of the full depth fills the queue.
	task automatic t_tx_full;
		push_pkt(QUEUE_DEPTH, 32'h5000, 5'h04);
		@(negedge clk);
		check(outbound_queue_full, 1'h1);
		expect_tx(QUEUE_DEPTH, 32'h5000, 5'h04);
		@(negedge clk);
		check(outbound_queue_full, 1'h0);
		$display("t_tx_full done");
	endtask : t_tx_full

	// Fill reaches 223, then 224: the third packet must be thrown away whole.
	task automatic t_rx_limit;
		i_umpa_mac_model.send_rx(223, 32'h1000, 5'h04, 1'h0);
		i_umpa_mac_model.send_rx(1, 32'h2000, 5'h16, 1'h0);
		i_umpa_mac_model.send_rx(2, 32'h3000, 5'h16, 1'h0);
		pop_expect(223, 32'h1000, 5'h04);
		pop_expect(1, 32'h2000, 5'h16);
		repeat (20) @(negedge clk);
		check(inbound_queue_empty, 1'h1);
		i_umpa_mac_model.send_rx(1, 32'h4000, 5'h04, 1'h0);
		pop_expect(1, 32'h4000, 5'h04);
		$display("t_rx_limit done");
	endtask : t_rx_limit

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_total++;
			close_out();
		end
	end

	initial
	begin
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		repeat (10) @(posedge clk);
		t_tx_back();
		t_tx_stall();
		t_tx_full();
		t_duplex();
		t_rx_limit();
		close_out();
	end
endmodule : test_udp_mac_packet_adapter

// ---- dv/umpa_adapter_props.sv ----
`timescale 1ns/1ps
// ***
// Checker
// ***
module umpa_adapter_props
	import umpa_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic mac_transmit_clock,
	input wire logic engine_rx_pop,
	input wire logic [4:0] engine_rx_empty_bytes,
	input wire logic inbound_queue_empty,
	input wire logic mac_tx_accept,
	input wire logic [DATA_W-1:0] mac_tx_word,
	input wire logic mac_tx_word_valid,
	input wire logic mac_tx_packet_start,
	input wire logic mac_tx_packet_end,
	input wire logic [4:0] mac_tx_empty
);
	sequence s_held;
		mac_tx_word_valid && $stable(mac_tx_word) && $stable(mac_tx_packet_end);
	endsequence
	// Two idle cycles cover the wait and claim states between packets.
	sequence s_gap;
		!mac_tx_word_valid ##1 !mac_tx_word_valid;
	endsequence
	a_tx_word_hold: assert property (@(posedge mac_transmit_clock) disable iff (!rst_b)
		mac_tx_word_valid && !mac_tx_accept |=> s_held) else $error("tx word moved");
	a_tx_valid_keep: assert property (@(posedge mac_transmit_clock) disable iff (!rst_b)
		mac_tx_word_valid && !mac_tx_packet_end |=> mac_tx_word_valid) else $error("valid gap");
	a_tx_end_drop: assert property (@(posedge mac_transmit_clock) disable iff (!rst_b)
		mac_tx_word_valid && mac_tx_accept && mac_tx_packet_end |=> s_gap) else $error("no gap");
	a_tx_start_first: assert property (@(posedge mac_transmit_clock) disable iff (!rst_b)
		$rose(mac_tx_word_valid) |-> mac_tx_packet_start) else $error("start missing");
	a_tx_start_once: assert property (@(posedge mac_transmit_clock) disable iff (!rst_b)
		mac_tx_word_valid && mac_tx_accept |=> !mac_tx_packet_start) else $error("start stuck");
	a_tx_empty_code: assert property (@(posedge mac_transmit_clock) disable iff (!rst_b)
		mac_tx_word_valid && mac_tx_packet_end |-> mac_tx_empty inside {5'h16, 5'h04})
		else $error("bad empty code");
	a_rx_no_vanish: assert property (@(posedge clk) disable iff (!rst_b)
		!engine_rx_pop && !inbound_queue_empty |=> !inbound_queue_empty) else $error("lost beat");
	a_rx_empty_code: assert property (@(posedge clk) disable iff (!rst_b)
		!inbound_queue_empty |-> engine_rx_empty_bytes inside {5'h16, 5'h04})
		else $error("bad rx empty");
endmodule : umpa_adapter_props

bind umpa_adapter umpa_adapter_props i_umpa_adapter_props (.clk, .rst_b, .mac_transmit_clock,
	.engine_rx_pop, .engine_rx_empty_bytes, .inbound_queue_empty, .mac_tx_accept, .mac_tx_word,
	.mac_tx_word_valid, .mac_tx_packet_start, .mac_tx_packet_end, .mac_tx_empty);

// ---- dv/umpa_mac_model.sv ----
`timescale 1ns/1ps
// ***
// MAC model
// ***
module umpa_mac_model
	import umpa_pkg::*;
(
	input wire logic mac_transmit_clock,
	input wire logic mac_receive_clock,
	input wire logic [1:0] stall_mode,
	output logic mac_tx_accept,
	input wire logic [DATA_W-1:0] mac_tx_word,
	input wire logic mac_tx_word_valid,
	input wire logic mac_tx_packet_end,
	input wire logic [4:0] mac_tx_empty,
	output logic [DATA_W-1:0] mac_rx_word,
	output logic mac_rx_word_valid,
	output logic mac_rx_packet_end,
	output logic [4:0] mac_rx_empty
);
	logic [1:0] tick_ff = 2'h0;
	logic [DATA_W+5:0] got[$];
	initial
	begin
		mac_tx_accept = 1'h0;
		mac_rx_word = '0;
		mac_rx_word_valid = 1'h0;
		mac_rx_packet_end = 1'h0;
		mac_rx_empty = 5'h00;
	end
	// Mode 1 takes a beat every other cycle, mode 3 one in four, so pauses hit mid-packet.
	always @(posedge mac_transmit_clock)
	begin
		tick_ff <= tick_ff + 2'h1;
		mac_tx_accept <= (tick_ff & stall_mode) == 2'h0;
		if (mac_tx_word_valid && mac_tx_accept)
			got.push_back({mac_tx_word, mac_tx_packet_end, mac_tx_empty});
	end
	// An idle line shows the inverse word, so a stale beat cannot pass for data.
	task automatic rx_idle(input int n);
		@(posedge mac_receive_clock);
		mac_rx_word_valid <= 1'h0;
		mac_rx_word <= ~mac_rx_word;
		mac_rx_packet_end <= 1'h0;
		repeat (n) @(posedge mac_receive_clock);
	endtask : rx_idle
	task automatic send_rx(input int n, input logic [31:0] base, input logic [4:0] emp,
		input logic gap);
		for (int i = 0; i < n; i++)
		begin
			@(posedge mac_receive_clock);
			mac_rx_word <= {8{base + 32'(i)}};
			mac_rx_word_valid <= 1'h1;
			mac_rx_packet_end <= (i == n - 1);
			mac_rx_empty <= emp;
			if (gap)
				rx_idle(0);
		end
		rx_idle(4);
	endtask : send_rx
endmodule : umpa_mac_model

// ---- hw/umpa_adapter.sv ----
`timescale 1ns/1ps
// Functional notes
// R1: Three clocks: engine, MAC transmit, MAC receive.
// R2: 256-bit show-ahead queues, 256-bit MAC streams.
// R3: Queues absorb engine/MAC rate mismatch.
// R4: Each direction owns a 512x258 async queue.
// R5: Engine counts packet ends, crossed to transmit clock.
// R6: Read count on claim; pending is difference.
// R7: Store only bit 4 of empty bytes.
// R8: Leave wait when pending nonzero, queue nonempty.
// R9: Claim lasts one cycle, pops first beat.
// R10: Pop follows accept and loads output word.
// R11: Valid stays high through end beat.
// R12: Accept low holds word, stops popping.
// R13: End beat accepted returns to wait, drops valid.
// R14: Store only with over 9 Kbyte free.
// R15: Fill below 224 stores, else discards.
// R16: Push follows valid; word delayed one clock.
// R17: Valid with end leaves transfer for wait.
// R18: Discard pushes nothing until end beat.
// R19: Directions share no control logic.
// R20: Store decision taken on first beat, held.

// ********************************************
// Reset release
// ********************************************
module umpa_reset_sync (
	input wire logic clk,
	input wire logic rst_b,
	output logic rst_sync_b
);
	logic [1:0] sync_ff;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			sync_ff <= 2'h0;
		else
			sync_ff <= {sync_ff[0], 1'b1};
	end

	assign rst_sync_b = sync_ff[1];
endmodule : umpa_reset_sync

// ********************************************
// Asynchronous show-ahead queue
// ********************************************
module umpa_async_fifo
	import umpa_pkg::*;
(
	input wire logic wr_clk,
	input wire logic wr_rst_b,
	input wire logic push,
	input wire umpa_beat_s push_beat,
	output logic full,
	output umpa_ptr_t fill_level,
	input wire logic rd_clk,
	input wire logic rd_rst_b,
	input wire logic pop,
	output umpa_beat_s head_beat,
	output logic empty
);
	umpa_beat_s store_ff [QUEUE_DEPTH];
	umpa_ptr_t wr_bin_ff;
	umpa_ptr_t wr_gray_ff;
	umpa_ptr_t rd_bin_ff;
	umpa_ptr_t rd_gray_ff;
	umpa_ptr_t rd_gray_meta_ff;
	umpa_ptr_t rd_gray_sync_ff;
	umpa_ptr_t wr_gray_meta_ff;
	umpa_ptr_t wr_gray_sync_ff;
	umpa_ptr_t nxt_wr_bin;
	umpa_ptr_t nxt_rd_bin;
	logic do_push;
	logic do_pop;

	if (QUEUE_DEPTH != (1 << QUEUE_ADDR_W) || $bits(umpa_beat_s) != QUEUE_BEAT_W)
	begin : g_bad_shape
		$error("umpa_async_fifo: queue depth or width inconsistent");
	end

	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign nxt_wr_bin = wr_bin_ff + umpa_ptr_t'(do_push);
	assign nxt_rd_bin = rd_bin_ff + umpa_ptr_t'(do_pop);

	// Storage has no reset; the pointers alone say what is valid.
	always_ff @(posedge wr_clk)
	begin
		if (do_push)
			store_ff[wr_bin_ff[QUEUE_ADDR_W-1:0]] <= push_beat;
	end

	always_ff @(posedge wr_clk or negedge wr_rst_b)
	begin
		if (!wr_rst_b)
		begin
			wr_bin_ff <= '0;
			wr_gray_ff <= '0;
			rd_gray_meta_ff <= '0;
			rd_gray_sync_ff <= '0;
		end
		else
		begin
			wr_bin_ff <= nxt_wr_bin;
			wr_gray_ff <= umpa_to_gray(nxt_wr_bin);
			rd_gray_meta_ff <= rd_gray_ff;
			rd_gray_sync_ff <= rd_gray_meta_ff;
		end
	end

	always_ff @(posedge rd_clk or negedge rd_rst_b)
	begin
		if (!rd_rst_b)
		begin
			rd_bin_ff <= '0;
			rd_gray_ff <= '0;
			wr_gray_meta_ff <= '0;
			wr_gray_sync_ff <= '0;
		end
		else
		begin
			rd_bin_ff <= nxt_rd_bin;
			rd_gray_ff <= umpa_to_gray(nxt_rd_bin);
			wr_gray_meta_ff <= wr_gray_ff;
			wr_gray_sync_ff <= wr_gray_meta_ff;
		end
	end

	// Fill level lags real reads by the sync delay, so it errs toward full.
	assign full = wr_gray_ff == {~rd_gray_sync_ff[QUEUE_ADDR_W:QUEUE_ADDR_W-1],
		rd_gray_sync_ff[QUEUE_ADDR_W-2:0]};
	assign fill_level = wr_bin_ff - umpa_from_gray(rd_gray_sync_ff);
	assign empty = rd_gray_ff == wr_gray_sync_ff;
	assign head_beat = store_ff[rd_bin_ff[QUEUE_ADDR_W-1:0]];
endmodule : umpa_async_fifo

// ********************************************
// Adapter top
// ********************************************
module umpa_adapter
	import umpa_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic mac_transmit_clock,
	input wire logic mac_receive_clock,
	input wire logic engine_tx_push,
	input wire logic [DATA_W-1:0] engine_tx_word,
	input wire logic engine_tx_end,
	input wire logic [4:0] final_beat_empty_bytes,
	output logic outbound_queue_full,
	input wire logic engine_rx_pop,
	output logic [DATA_W-1:0] engine_rx_word,
	output logic engine_rx_end,
	output logic [4:0] engine_rx_empty_bytes,
	output logic inbound_queue_empty,
	input wire logic mac_tx_accept,
	output logic [DATA_W-1:0] mac_tx_word,
	output logic mac_tx_word_valid,
	output logic mac_tx_packet_start,
	output logic mac_tx_packet_end,
	output logic [4:0] mac_tx_empty,
	input wire logic [DATA_W-1:0] mac_rx_word,
	input wire logic mac_rx_word_valid,
	input wire logic mac_rx_packet_end,
	input wire logic [4:0] mac_rx_empty
);
	logic rst_eng_b;
	logic rst_tx_b;
	logic rst_rx_b;

	umpa_reset_sync u_rst_eng (.clk(clk), .rst_b(rst_b), .rst_sync_b(rst_eng_b)); // R1
	umpa_reset_sync u_rst_tx (.clk(mac_transmit_clock), .rst_b(rst_b), .rst_sync_b(rst_tx_b));
	umpa_reset_sync u_rst_rx (.clk(mac_receive_clock), .rst_b(rst_b), .rst_sync_b(rst_rx_b));

	// ********************************************
	// Transmit path, engine side
	// ********************************************
	umpa_beat_s tx_push_beat;
	umpa_beat_s tx_head;
	logic outbound_queue_empty;
	logic outbound_queue_pop;
	logic eng_end_taken_ff;
	umpa_ptr_t eng_pkt_bin_ff;
	umpa_ptr_t eng_pkt_gray_ff;
	umpa_ptr_t nxt_eng_pkt_bin;

	assign tx_push_beat.word = engine_tx_word;
	assign tx_push_beat.packet_end = engine_tx_end;
	assign tx_push_beat.empty_hi = final_beat_empty_bytes[EMPTY_SEL_BIT]; // R7

	umpa_async_fifo u_outbound_queue ( // R4 R3 R2
		.wr_clk(clk),
		.wr_rst_b(rst_eng_b),
		.push(engine_tx_push),
		.push_beat(tx_push_beat),
		.full(outbound_queue_full),
		.fill_level(),
		.rd_clk(mac_transmit_clock),
		.rd_rst_b(rst_tx_b),
		.pop(outbound_queue_pop),
		.head_beat(tx_head),
		.empty(outbound_queue_empty)
	);

	// The count moves one cycle after the end beat lands, so the queue pointer
	// is always ahead of it and a claimed packet is wholly readable.
	assign nxt_eng_pkt_bin = eng_pkt_bin_ff + umpa_ptr_t'(eng_end_taken_ff);

	always_ff @(posedge clk or negedge rst_eng_b)
	begin
		if (!rst_eng_b)
		begin
			eng_end_taken_ff <= 1'b0;
			eng_pkt_bin_ff <= '0;
			eng_pkt_gray_ff <= '0;
		end
		else
		begin
			eng_end_taken_ff <= engine_tx_push && engine_tx_end && !outbound_queue_full; // R5
			eng_pkt_bin_ff <= nxt_eng_pkt_bin; // R5
			eng_pkt_gray_ff <= umpa_to_gray(nxt_eng_pkt_bin);
		end
	end

	// ********************************************
	// Transmit path, MAC side
	// ********************************************
	umpa_tx_state_e tx_state_ff;
	umpa_tx_state_e nxt_tx_state;
	umpa_ptr_t tx_pkt_gray_meta_ff;
	umpa_ptr_t tx_pkt_gray_sync_ff;
	umpa_ptr_t tx_read_pkt_ff;
	umpa_ptr_t pending_packet_count;
	logic [DATA_W-1:0] mac_tx_word_ff;
	logic mac_tx_word_valid_ff;
	logic mac_tx_packet_start_ff;
	logic mac_tx_packet_end_ff;
	logic [4:0] mac_tx_empty_ff;

	always_ff @(posedge mac_transmit_clock or negedge rst_tx_b)
	begin
		if (!rst_tx_b)
		begin
			tx_pkt_gray_meta_ff <= '0;
			tx_pkt_gray_sync_ff <= '0;
		end
		else
		begin
			tx_pkt_gray_meta_ff <= eng_pkt_gray_ff; // R5
			tx_pkt_gray_sync_ff <= tx_pkt_gray_meta_ff;
		end
	end

	assign pending_packet_count = umpa_from_gray(tx_pkt_gray_sync_ff) - tx_read_pkt_ff; // R6

	always_comb
	begin
		nxt_tx_state = tx_state_ff;
		outbound_queue_pop = 1'b0;
		unique case (tx_state_ff)
			TX_WAIT:
			begin
				if (pending_packet_count != '0 && !outbound_queue_empty) // R8
					nxt_tx_state = TX_CLAIM;
			end
			TX_CLAIM:
			begin
				outbound_queue_pop = 1'b1; // R9
				nxt_tx_state = TX_TRANSFER;
			end
			TX_TRANSFER:
			begin
				// Without accept nothing pops, so the word on the pins stays put.
				outbound_queue_pop = mac_tx_accept && !mac_tx_packet_end_ff
					&& !outbound_queue_empty; // R10 R12
				if (mac_tx_accept && mac_tx_packet_end_ff)
					nxt_tx_state = TX_WAIT; // R13
			end
			default:
			begin
				nxt_tx_state = TX_WAIT;
			end
		endcase
	end

	always_ff @(posedge mac_transmit_clock or negedge rst_tx_b)
	begin
		if (!rst_tx_b)
		begin
			tx_state_ff <= TX_WAIT;
			tx_read_pkt_ff <= '0;
		end
		else
		begin
			tx_state_ff <= nxt_tx_state;
			if (tx_state_ff == TX_CLAIM)
				tx_read_pkt_ff <= tx_read_pkt_ff + umpa_ptr_t'(1); // R6 R9
		end
	end

	always_ff @(posedge mac_transmit_clock or negedge rst_tx_b)
	begin
		if (!rst_tx_b)
		begin
			mac_tx_word_ff <= '0;
			mac_tx_packet_end_ff <= 1'b0;
			mac_tx_empty_ff <= 5'h00;
		end
		else if (outbound_queue_pop)
		begin
			mac_tx_word_ff <= tx_head.word; // R10
			mac_tx_packet_end_ff <= tx_head.packet_end;
			mac_tx_empty_ff <= tx_head.packet_end ? umpa_empty_bytes(tx_head.empty_hi) : 5'h00;
		end
	end

	always_ff @(posedge mac_transmit_clock or negedge rst_tx_b)
	begin
		if (!rst_tx_b)
		begin
			mac_tx_word_valid_ff <= 1'b0;
			mac_tx_packet_start_ff <= 1'b0;
		end
		else
		begin
			if (tx_state_ff == TX_CLAIM)
				mac_tx_word_valid_ff <= 1'b1; // R11
			else if (tx_state_ff == TX_TRANSFER && mac_tx_accept && mac_tx_packet_end_ff)
				mac_tx_word_valid_ff <= 1'b0; // R13
			if (tx_state_ff == TX_CLAIM)
				mac_tx_packet_start_ff <= 1'b1;
			else if (mac_tx_accept)
				mac_tx_packet_start_ff <= 1'b0;
		end
	end

	assign mac_tx_word = mac_tx_word_ff;
	assign mac_tx_word_valid = mac_tx_word_valid_ff;
	assign mac_tx_packet_start = mac_tx_packet_start_ff;
	assign mac_tx_packet_end = mac_tx_packet_end_ff;
	assign mac_tx_empty = mac_tx_empty_ff;

	// ********************************************
	// Receive path, MAC side
	// ********************************************
	umpa_rx_state_e rx_state_ff;
	umpa_rx_state_e nxt_rx_state;
	umpa_beat_s inbound_push_word_ff;
	umpa_beat_s rx_head;
	umpa_ptr_t inbound_fill_level;
	logic inbound_queue_push_ff;
	logic nxt_inbound_queue_push;
	logic rx_room;

	// Room for one largest packet is judged against the lagging fill level.
	assign rx_room = inbound_fill_level < RX_FILL_LIMIT; // R14 R15

	always_comb
	begin
		nxt_rx_state = rx_state_ff;
		nxt_inbound_queue_push = 1'b0;
		unique case (rx_state_ff)
			RX_WAIT:
			begin
				if (mac_rx_word_valid)
				begin
					nxt_inbound_queue_push = rx_room; // R20
					if (!mac_rx_packet_end)
						nxt_rx_state = rx_room ? RX_TRANSFER : RX_DISCARD; // R20 R15
				end
			end
			RX_TRANSFER:
			begin
				nxt_inbound_queue_push = mac_rx_word_valid; // R16
				if (mac_rx_word_valid && mac_rx_packet_end)
					nxt_rx_state = RX_WAIT; // R17
			end
			RX_DISCARD:
			begin
				if (mac_rx_word_valid && mac_rx_packet_end)
					nxt_rx_state = RX_WAIT; // R18
			end
			default:
			begin
				nxt_rx_state = RX_WAIT;
			end
		endcase
	end

	always_ff @(posedge mac_receive_clock or negedge rst_rx_b)
	begin
		if (!rst_rx_b)
		begin
			rx_state_ff <= RX_WAIT;
			inbound_queue_push_ff <= 1'b0;
			inbound_push_word_ff <= '0;
		end
		else
		begin
			rx_state_ff <= nxt_rx_state;
			inbound_queue_push_ff <= nxt_inbound_queue_push; // R16 R18
			inbound_push_word_ff.word <= mac_rx_word; // R16
			inbound_push_word_ff.packet_end <= mac_rx_packet_end;
			inbound_push_word_ff.empty_hi <= mac_rx_empty[EMPTY_SEL_BIT];
		end
	end

	umpa_async_fifo u_inbound_queue ( // R4 R19
		.wr_clk(mac_receive_clock),
		.wr_rst_b(rst_rx_b),
		.push(inbound_queue_push_ff),
		.push_beat(inbound_push_word_ff),
		.full(),
		.fill_level(inbound_fill_level),
		.rd_clk(clk),
		.rd_rst_b(rst_eng_b),
		.pop(engine_rx_pop),
		.head_beat(rx_head),
		.empty(inbound_queue_empty)
	);

	// Show-ahead: the head entry is visible before the engine pops it.
	assign engine_rx_word = rx_head.word;
	assign engine_rx_end = rx_head.packet_end;
	assign engine_rx_empty_bytes = umpa_empty_bytes(rx_head.empty_hi);
endmodule : umpa_adapter

// ---- hw/umpa_pkg.sv ----
package umpa_pkg;

	// ********************************************
	// Sizes and limits
	// ********************************************
	localparam int unsigned DATA_W = 256;
	localparam int unsigned QUEUE_ADDR_W = 9;
	localparam int unsigned QUEUE_DEPTH = 512;
	localparam int unsigned QUEUE_BEAT_W = 258;
	localparam logic [9:0] RX_FILL_LIMIT = 10'h0e0;
	localparam logic [4:0] EMPTY_SHORT = 5'h16;
	localparam logic [4:0] EMPTY_LONG = 5'h04;
	localparam int unsigned EMPTY_SEL_BIT = 4;

	// ********************************************
	// Types
	// ********************************************
	typedef logic [QUEUE_ADDR_W:0] umpa_ptr_t;

	typedef struct packed {
		logic [DATA_W-1:0] word;
		logic packet_end;
		logic empty_hi;
	} umpa_beat_s;

	typedef enum logic [2:0] {
		TX_WAIT = 3'h1,
		TX_CLAIM = 3'h2,
		TX_TRANSFER = 3'h4
	} umpa_tx_state_e;

	typedef enum logic [2:0] {
		RX_WAIT = 3'h1,
		RX_TRANSFER = 3'h2,
		RX_DISCARD = 3'h4
	} umpa_rx_state_e;

	// ********************************************
	// Helpers
	// ********************************************
	function automatic umpa_ptr_t umpa_to_gray(input umpa_ptr_t bin);
		return bin ^ (bin >> 1);
	endfunction : umpa_to_gray

	function automatic umpa_ptr_t umpa_from_gray(input umpa_ptr_t gray);
		umpa_ptr_t bin;
		bin[QUEUE_ADDR_W] = gray[QUEUE_ADDR_W];
		for (int i = QUEUE_ADDR_W - 1; i >= 0; i--)
		begin
			bin[i] = bin[i+1] ^ gray[i];
		end
		return bin;
	endfunction : umpa_from_gray

	// The engine only ever reports two empty counts, so one bit restores either.
	function automatic logic [4:0] umpa_empty_bytes(input logic empty_hi);
		return empty_hi ? EMPTY_SHORT : EMPTY_LONG;
	endfunction : umpa_empty_bytes

endpackage : umpa_pkg
